// ---- logic/rsp_pkg.sv ----
// Purpose: Constants and types of the raw frame path
// Assumes: 16-bit memory words, first byte high
// Notes: Offsets are byte addresses
//
// How it works
// R1 - Raw frame mode on socket 0 only
// R2 - Stored frame is length header, bytes, four CRC bytes
// R3 - Frame bytes hold addresses, type and payload
// R4 - Host reads the two CRC words out of the receive port and drops them
// R5 - Host reads frame as 16-bit words, odd length rounded up
// R6 - After header, frame and CRC the host issues receive-done
// R7 - Receive-done frees words read since last one
// R8 - When memory runs out, rest of a frame is silently lost
// R9 - With filter set, only own-address and broadcast frames are kept
// R10 - Open in raw mode reports raw-open state; host polls it
// R11 - Host computes free space from memory size and received size
// R12 - Below 1528 free bytes host closes, drains and reopens
// R13 - Close shows closed state while stored data stays readable
// R14 - Host drains by deducting header, even length and CRC per frame
// R15 - Host keeps send frames within transmit memory and maximum length
// R16 - Host writes frame without header; CRC is appended
// R17 - Frames under 60 bytes padded with zeros to 60
// R18 - Host writes words, then write size, then send command
// R19 - No timeout event is ever raised for a raw send

package rsp_pkg;
    // ==========================================
    // Memory geometry
    localparam int MEM_WORDS = 1024;
    localparam int PTR_W = 11;
    localparam int SIZE_W = 12;
    localparam logic [7:0] RX_MEM_KB = 8'h02;

    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STATE = 8'h08;
    localparam logic [7:0] OFF_RX_SIZE = 8'h0c;
    localparam logic [7:0] OFF_RX_FIFO = 8'h10;
    localparam logic [7:0] OFF_TX_FIFO = 8'h14;
    localparam logic [7:0] OFF_TX_FREE = 8'h18;
    localparam logic [7:0] OFF_TX_WRSIZE = 8'h1c;
    localparam logic [7:0] OFF_RX_MEM_KB = 8'h20;
    localparam logic [7:0] OFF_EVENT = 8'h24;
    localparam logic [7:0] OFF_MAC_HI = 8'h28;
    localparam logic [7:0] OFF_MAC_LO = 8'h2c;

    // ==========================================
    // Fields, codes and reset values
    localparam logic [3:0] MODE_RAW = 4'h4;
    localparam int MODE_FILTER_BIT = 6;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CMD_OPEN = 8'h01;
    localparam logic [7:0] CMD_CLOSE = 8'h10;
    localparam logic [7:0] CMD_SEND = 8'h20;
    localparam logic [7:0] CMD_RECEIVE_DONE_COMMAND = 8'h40;
    localparam logic [7:0] SOCKET_CLOSED_STATE = 8'h00;
    localparam logic [7:0] RAW_FRAME_OPEN_STATE = 8'h42;
    localparam int EVT_SEND_OK_BIT = 4;
    localparam int EVT_TIMEOUT_BIT = 3;
    localparam logic [47:0] MAC_RST = 48'h0000_0000_0000;
    localparam logic [SIZE_W-1:0] MIN_FRAME_BYTES = 12'h03c;
    localparam logic [SIZE_W-1:0] ADDR_BYTES = 12'h006;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ==========================================
    // Carriers and states
    typedef struct packed {
        logic last;
        logic [7:0] data;
        logic [31:0] crc;
    } rsp_rx_byte_s;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } rsp_tx_byte_s;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_DATA = 3'h1,
        RX_CRC_HI = 3'h3,
        RX_CRC_LO = 3'h2,
        RX_HDR = 3'h6,
        RX_DROP = 3'h7
    } rsp_rx_state_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_RUN = 2'h1,
        TX_FIN = 2'h3
    } rsp_tx_state_e;
endpackage

// ---- logic/rsp_buf2.sv ----
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock, synchronous reset
// Notes: Ready drops only when full
`timescale 1ns/10ps
module rsp_buf2 #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic [W-1:0] slot_ff [2];
    logic [W-1:0] nxt_slot [2];
    logic wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = slot_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_slot = slot_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_slot[wr_ff] = in_data;
            nxt_wr = ~wr_ff;
        end
        if (pop) begin
            nxt_rd = ~rd_ff;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'h1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            slot_ff[0] <= '0;
            slot_ff[1] <= '0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            slot_ff <= nxt_slot;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// ---- logic/rsp_socket0.sv ----
// Purpose: Socket 0 raw frame path
// Assumes: CRC arrives beside last byte
// Notes: Zero wait states
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
module rsp_socket0 (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic mac_rx_valid,
    input wire rsp_pkg::rsp_rx_byte_s mac_rx_byte,
    output logic mac_rx_ready,
    output logic mac_tx_valid,
    output rsp_pkg::rsp_tx_byte_s mac_tx_byte,
    input wire logic mac_tx_ready
);
    // ==========================================
    // Helpers
    function automatic logic [rsp_pkg::SIZE_W-1:0] words_to_bytes(input logic [rsp_pkg::PTR_W-1:0] w);
        words_to_bytes = {w, 1'b0};
    endfunction

    function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [rsp_pkg::SIZE_W-1:0] idx);
        mac_byte = mac[8'(47 - 8 * int'(idx[2:0])) -: 8];
    endfunction

    // ==========================================
    // Storage
    logic [15:0] rx_mem [rsp_pkg::MEM_WORDS];
    logic [15:0] tx_mem [rsp_pkg::MEM_WORDS];

    // ==========================================
    // Bus and socket state
    logic wr_pend_ff, nxt_wr_pend;
    logic [7:0] wr_addr_ff, nxt_wr_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [7:0] mode_ff, nxt_mode;
    logic [7:0] state_ff, nxt_state;
    logic [47:0] mac_ff, nxt_mac;
    logic [rsp_pkg::SIZE_W-1:0] rx_size_ff, nxt_rx_size;
    logic [rsp_pkg::PTR_W-1:0] rx_rd_ptr_ff, nxt_rx_rd_ptr;
    logic [rsp_pkg::PTR_W-1:0] rx_rel_ptr_ff, nxt_rx_rel_ptr;
    logic [rsp_pkg::PTR_W-1:0] tx_wr_ptr_ff, nxt_tx_wr_ptr;
    logic [rsp_pkg::SIZE_W-1:0] tx_wrsize_ff, nxt_tx_wrsize;
    logic send_ok_ff, nxt_send_ok;
    logic rd_req, wr_act, tx_push;
    logic [7:0] rd_off;
    logic cmd_open, cmd_close, cmd_send, cmd_receive_done_command, is_open;
    logic [rsp_pkg::SIZE_W-1:0] rx_add, tx_free;

    // Receive and transmit engine state
    rsp_pkg::rsp_rx_state_e rx_st_ff, nxt_rx_st;
    logic [rsp_pkg::PTR_W-1:0] rx_wr_ptr_ff, nxt_rx_wr_ptr;
    logic [rsp_pkg::PTR_W-1:0] rx_base_ff, nxt_rx_base;
    logic [rsp_pkg::SIZE_W-1:0] rx_cnt_ff, nxt_rx_cnt;
    logic [7:0] rx_hi_ff, nxt_rx_hi;
    logic own_ok_ff, nxt_own_ok, bc_ok_ff, nxt_bc_ok;
    logic [31:0] rx_crc_ff, nxt_rx_crc;
    logic rx_we;
    logic [rsp_pkg::PTR_W-1:0] rx_wa;
    logic [15:0] rx_wd;
    logic rx_room, fb_valid, fb_ready;
    rsp_pkg::rsp_rx_byte_s fb;
    rsp_pkg::rsp_tx_state_e tx_st_ff, nxt_tx_st;
    logic [rsp_pkg::PTR_W-1:0] tx_rd_ptr_ff, nxt_tx_rd_ptr;
    logic [rsp_pkg::SIZE_W-1:0] tx_len_ff, nxt_tx_len, tx_cnt_ff, nxt_tx_cnt, tx_total;
    logic tx_valid_ff, nxt_tx_valid;
    rsp_pkg::rsp_tx_byte_s tx_out_ff, nxt_tx_out;
    logic [15:0] tx_word;
    logic tx_done;

    // ==========================================
    // AHB-Lite slave
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign rd_req = hsel && htrans[1] && hready && !hwrite && (hsize == rsp_pkg::HSIZE_WORD);
    assign rd_off = haddr[7:0];
    assign wr_act = wr_pend_ff;
    assign cmd_open = wr_act && (wr_addr_ff == rsp_pkg::OFF_CMD) && (hwdata[7:0] == rsp_pkg::CMD_OPEN);
    assign cmd_close = wr_act && (wr_addr_ff == rsp_pkg::OFF_CMD) && (hwdata[7:0] == rsp_pkg::CMD_CLOSE);
    assign cmd_send = wr_act && (wr_addr_ff == rsp_pkg::OFF_CMD) && (hwdata[7:0] == rsp_pkg::CMD_SEND);
    assign cmd_receive_done_command = wr_act && (wr_addr_ff == rsp_pkg::OFF_CMD) && (hwdata[7:0] == rsp_pkg::CMD_RECEIVE_DONE_COMMAND);
    assign is_open = (state_ff == rsp_pkg::RAW_FRAME_OPEN_STATE);
    assign tx_free = 12'h800 - words_to_bytes(tx_wr_ptr_ff - tx_rd_ptr_ff);
    assign tx_push = wr_act && (wr_addr_ff == rsp_pkg::OFF_TX_FIFO) && (tx_free != 12'h000);

    always_comb begin
        nxt_wr_pend = hsel && htrans[1] && hready && hwrite && (hsize == rsp_pkg::HSIZE_WORD);
        nxt_wr_addr = haddr[7:0];
        nxt_rdata = rdata_ff;
        nxt_mode = mode_ff;
        nxt_state = state_ff;
        nxt_mac = mac_ff;
        nxt_rx_size = rx_size_ff + rx_add;
        nxt_rx_rd_ptr = rx_rd_ptr_ff;
        nxt_rx_rel_ptr = rx_rel_ptr_ff;
        nxt_tx_wr_ptr = tx_wr_ptr_ff;
        nxt_tx_wrsize = tx_wrsize_ff;
        nxt_send_ok = send_ok_ff;
        if (rd_req) begin
            case (rd_off)
                rsp_pkg::OFF_MODE: nxt_rdata = {24'h000000, mode_ff};
                rsp_pkg::OFF_STATE: nxt_rdata = {24'h000000, state_ff};
                rsp_pkg::OFF_RX_SIZE: nxt_rdata = {20'h00000, rx_size_ff};
                rsp_pkg::OFF_RX_FIFO: begin
                    // Pops one word, also while closed
                    nxt_rdata = {16'h0000, rx_mem[rx_rd_ptr_ff[rsp_pkg::PTR_W-2:0]]}; // R4 R5 R13
                    nxt_rx_rd_ptr = rx_rd_ptr_ff + 11'h001;
                end
                rsp_pkg::OFF_TX_FREE: nxt_rdata = {20'h00000, tx_free};
                rsp_pkg::OFF_TX_WRSIZE: nxt_rdata = {20'h00000, tx_wrsize_ff};
                rsp_pkg::OFF_RX_MEM_KB: nxt_rdata = {24'h000000, rsp_pkg::RX_MEM_KB}; // R11
                rsp_pkg::OFF_EVENT: nxt_rdata = 32'(send_ok_ff) << rsp_pkg::EVT_SEND_OK_BIT;
                rsp_pkg::OFF_MAC_HI: nxt_rdata = {16'h0000, mac_ff[47:32]};
                rsp_pkg::OFF_MAC_LO: nxt_rdata = mac_ff[31:0];
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
        if (wr_act) begin
            case (wr_addr_ff)
                rsp_pkg::OFF_MODE: nxt_mode = hwdata[7:0];
                rsp_pkg::OFF_TX_WRSIZE: nxt_tx_wrsize = hwdata[rsp_pkg::SIZE_W-1:0]; // R18
                rsp_pkg::OFF_EVENT: begin
                    if (hwdata[rsp_pkg::EVT_SEND_OK_BIT]) begin
                        nxt_send_ok = 1'b0;
                    end
                end
                rsp_pkg::OFF_MAC_HI: nxt_mac[47:32] = hwdata[15:0];
                rsp_pkg::OFF_MAC_LO: nxt_mac[31:0] = hwdata;
                default: nxt_mac = mac_ff;
            endcase
        end
        if (tx_push) begin
            nxt_tx_wr_ptr = tx_wr_ptr_ff + 11'h001;
        end
        if (cmd_open && !is_open) begin
            if (mode_ff[3:0] == rsp_pkg::MODE_RAW) begin
                // Fresh open starts empty
                nxt_state = rsp_pkg::RAW_FRAME_OPEN_STATE; // R1 R10
                nxt_rx_size = rx_add;
                nxt_rx_rd_ptr = rx_wr_ptr_ff;
                nxt_rx_rel_ptr = rx_wr_ptr_ff;
            end
        end
        if (cmd_close) begin
            nxt_state = rsp_pkg::SOCKET_CLOSED_STATE; // R13
        end
        if (cmd_receive_done_command) begin
            // Free words read since last one
            nxt_rx_size = rx_size_ff + rx_add - words_to_bytes(rx_rd_ptr_ff - rx_rel_ptr_ff); // R7
            nxt_rx_rel_ptr = rx_rd_ptr_ff; // R7
        end
        if (tx_done) begin
            nxt_send_ok = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            mode_ff <= rsp_pkg::MODE_RST;
            state_ff <= rsp_pkg::SOCKET_CLOSED_STATE;
            mac_ff <= rsp_pkg::MAC_RST;
            rx_size_ff <= 12'h000;
            rx_rd_ptr_ff <= 11'h000;
            rx_rel_ptr_ff <= 11'h000;
            tx_wr_ptr_ff <= 11'h000;
            tx_wrsize_ff <= 12'h000;
            send_ok_ff <= 1'b0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            rdata_ff <= nxt_rdata;
            mode_ff <= nxt_mode;
            state_ff <= nxt_state;
            mac_ff <= nxt_mac;
            rx_size_ff <= nxt_rx_size;
            rx_rd_ptr_ff <= nxt_rx_rd_ptr;
            rx_rel_ptr_ff <= nxt_rx_rel_ptr;
            tx_wr_ptr_ff <= nxt_tx_wr_ptr;
            tx_wrsize_ff <= nxt_tx_wrsize;
            send_ok_ff <= nxt_send_ok;
        end
        if (tx_push) begin
            tx_mem[tx_wr_ptr_ff[rsp_pkg::PTR_W-2:0]] <= hwdata[15:0]; // R18
        end
        if (rx_we) begin
            rx_mem[rx_wa[rsp_pkg::PTR_W-2:0]] <= rx_wd;
        end
    end

    // ==========================================
    // Receive path
    rsp_buf2 #(
        .W($bits(rsp_pkg::rsp_rx_byte_s))
    ) u_rx_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(mac_rx_valid),
        .in_data(mac_rx_byte),
        .in_ready(mac_rx_ready),
        .out_valid(fb_valid),
        .out_data(fb),
        .out_ready(fb_ready)
    );

    assign rx_room = ((rx_wr_ptr_ff - rx_rel_ptr_ff) != 11'h400);

    always_comb begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_wr_ptr = rx_wr_ptr_ff;
        nxt_rx_base = rx_base_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_hi = rx_hi_ff;
        nxt_own_ok = own_ok_ff;
        nxt_bc_ok = bc_ok_ff;
        nxt_rx_crc = rx_crc_ff;
        fb_ready = 1'b0;
        rx_we = 1'b0;
        rx_wa = rx_wr_ptr_ff;
        rx_wd = 16'h0000;
        rx_add = 12'h000;
        case (rx_st_ff)
            rsp_pkg::RX_IDLE: begin
                if (fb_valid) begin
                    nxt_rx_cnt = 12'h000;
                    nxt_own_ok = 1'b1;
                    nxt_bc_ok = 1'b1;
                    if (is_open && rx_room) begin
                        // Reserve header slot
                        nxt_rx_base = rx_wr_ptr_ff; // R2
                        nxt_rx_wr_ptr = rx_wr_ptr_ff + 11'h001;
                        nxt_rx_st = rsp_pkg::RX_DATA;
                    end else begin
                        nxt_rx_st = rsp_pkg::RX_DROP;
                    end
                end
            end
            rsp_pkg::RX_DATA: begin
                fb_ready = 1'b1;
                if (fb_valid) begin
                    nxt_rx_cnt = rx_cnt_ff + 12'h001;
                    if (rx_cnt_ff < rsp_pkg::ADDR_BYTES) begin
                        nxt_own_ok = own_ok_ff && (fb.data == mac_byte(mac_ff, rx_cnt_ff));
                        nxt_bc_ok = bc_ok_ff && (fb.data == 8'hff);
                    end
                    if (!rx_cnt_ff[0]) begin
                        nxt_rx_hi = fb.data;
                    end
                    if (rx_cnt_ff[0] || fb.last) begin
                        // Full memory drops rest
                        rx_we = rx_room; // R3 R8
                        rx_wd = rx_cnt_ff[0] ? {rx_hi_ff, fb.data} : {fb.data, 8'h00};
                        nxt_rx_wr_ptr = rx_room ? rx_wr_ptr_ff + 11'h001 : rx_wr_ptr_ff;
                    end
                    if (fb.last) begin
                        nxt_rx_crc = fb.crc;
                        nxt_rx_st = rsp_pkg::RX_CRC_HI;
                    end
                end
            end
            rsp_pkg::RX_CRC_HI: begin
                if (mode_ff[rsp_pkg::MODE_FILTER_BIT] && !own_ok_ff && !bc_ok_ff) begin
                    nxt_rx_wr_ptr = rx_base_ff; // R9
                    nxt_rx_st = rsp_pkg::RX_IDLE;
                end else begin
                    rx_we = rx_room; // R2 R8
                    rx_wd = rx_crc_ff[31:16];
                    nxt_rx_wr_ptr = rx_room ? rx_wr_ptr_ff + 11'h001 : rx_wr_ptr_ff;
                    nxt_rx_st = rsp_pkg::RX_CRC_LO;
                end
            end
            rsp_pkg::RX_CRC_LO: begin
                rx_we = rx_room; // R2 R8
                rx_wd = rx_crc_ff[15:0];
                nxt_rx_wr_ptr = rx_room ? rx_wr_ptr_ff + 11'h001 : rx_wr_ptr_ff;
                nxt_rx_st = rsp_pkg::RX_HDR;
            end
            rsp_pkg::RX_HDR: begin
                // Full length even if truncated
                rx_we = 1'b1; // R2 R8
                rx_wa = rx_base_ff;
                rx_wd = {4'h0, rx_cnt_ff};
                rx_add = words_to_bytes(rx_wr_ptr_ff - rx_base_ff);
                nxt_rx_st = rsp_pkg::RX_IDLE;
            end
            rsp_pkg::RX_DROP: begin
                fb_ready = 1'b1;
                if (fb_valid && fb.last) begin
                    nxt_rx_st = rsp_pkg::RX_IDLE;
                end
            end
            default: nxt_rx_st = rsp_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_st_ff <= rsp_pkg::RX_IDLE;
            rx_wr_ptr_ff <= 11'h000;
            rx_base_ff <= 11'h000;
            rx_cnt_ff <= 12'h000;
            rx_hi_ff <= 8'h00;
            own_ok_ff <= 1'b0;
            bc_ok_ff <= 1'b0;
            rx_crc_ff <= 32'h0000_0000;
        end else begin
            rx_st_ff <= nxt_rx_st;
            rx_wr_ptr_ff <= nxt_rx_wr_ptr;
            rx_base_ff <= nxt_rx_base;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_hi_ff <= nxt_rx_hi;
            own_ok_ff <= nxt_own_ok;
            bc_ok_ff <= nxt_bc_ok;
            rx_crc_ff <= nxt_rx_crc;
        end
    end

    // ==========================================
    // Transmit engine
    assign mac_tx_valid = tx_valid_ff;
    assign mac_tx_byte = tx_out_ff;
    assign tx_total = (tx_len_ff < rsp_pkg::MIN_FRAME_BYTES) ? rsp_pkg::MIN_FRAME_BYTES : tx_len_ff; // R17
    assign tx_word = tx_mem[10'(tx_rd_ptr_ff + tx_cnt_ff[rsp_pkg::SIZE_W-1:1])];
    assign tx_done = (tx_st_ff == rsp_pkg::TX_FIN);

    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_rd_ptr = tx_rd_ptr_ff;
        nxt_tx_len = tx_len_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_valid = tx_valid_ff && !mac_tx_ready;
        nxt_tx_out = tx_out_ff;
        case (tx_st_ff)
            rsp_pkg::TX_IDLE: begin
                if (cmd_send && is_open && (tx_wrsize_ff != 12'h000)) begin
                    nxt_tx_len = tx_wrsize_ff; // R16
                    nxt_tx_cnt = 12'h000;
                    nxt_tx_st = rsp_pkg::TX_RUN;
                end
            end
            rsp_pkg::TX_RUN: begin
                if ((!tx_valid_ff || mac_tx_ready) && (tx_cnt_ff < tx_total)) begin
                    nxt_tx_valid = 1'b1;
                    nxt_tx_out.last = (tx_cnt_ff == tx_total - 12'h001);
                    if (tx_cnt_ff < tx_len_ff) begin
                        nxt_tx_out.data = tx_cnt_ff[0] ? tx_word[7:0] : tx_word[15:8];
                    end else begin
                        nxt_tx_out.data = 8'h00; // R17
                    end
                    nxt_tx_cnt = tx_cnt_ff + 12'h001;
                end
                if (tx_valid_ff && mac_tx_ready && tx_out_ff.last) begin
                    nxt_tx_st = rsp_pkg::TX_FIN;
                end
            end
            rsp_pkg::TX_FIN: begin
                // No timeout path
                nxt_tx_rd_ptr = tx_rd_ptr_ff + tx_len_ff[rsp_pkg::SIZE_W-1:1] + 11'(tx_len_ff[0]); // R19
                nxt_tx_st = rsp_pkg::TX_IDLE;
            end
            default: nxt_tx_st = rsp_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_st_ff <= rsp_pkg::TX_IDLE;
            tx_rd_ptr_ff <= 11'h000;
            tx_len_ff <= 12'h000;
            tx_cnt_ff <= 12'h000;
            tx_valid_ff <= 1'b0;
            tx_out_ff <= '0;
        end else begin
            tx_st_ff <= nxt_tx_st;
            tx_rd_ptr_ff <= nxt_tx_rd_ptr;
            tx_len_ff <= nxt_tx_len;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_valid_ff <= nxt_tx_valid;
            tx_out_ff <= nxt_tx_out;
        end
    end
endmodule

// ---- bench/rsp_socket0_assertions.sv ----
// Purpose: Port checks
// Assumes: Zero wait state bus slave
// Notes: Bound into rsp_socket0
`timescale 1ns/10ps
module rsp_socket0_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic mac_rx_ready,
    input wire logic mac_tx_valid,
    input wire rsp_pkg::rsp_tx_byte_s mac_tx_byte,
    input wire logic mac_tx_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [11:0] tx_cnt_ff;
    logic [11:0] nxt_tx_cnt;
    always_comb begin
        nxt_tx_cnt = tx_cnt_ff;
        if (mac_tx_valid && mac_tx_ready) begin
            nxt_tx_cnt = mac_tx_byte.last ? 12'h000 : tx_cnt_ff + 12'h001;
        end
    end
    always_ff @(posedge core_clk) begin
        tx_cnt_ff <= rst ? 12'h000 : nxt_tx_cnt;
    end
    sequence tx_wait_s;
        mac_tx_valid && !mac_tx_ready;
    endsequence
    sequence tx_last_s;
        mac_tx_valid && mac_tx_ready && mac_tx_byte.last;
    endsequence
    ready_one_a: assert property (hreadyout) else $error("hreadyout low");
    okay_resp_a: assert property (!hresp) else $error("hresp not okay");
    rdata_hold_a: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("hrdata moved without read");
    tx_hold_a: assert property (tx_wait_s |=> mac_tx_valid && $stable(mac_tx_byte))
        else $error("tx byte changed while stalled");
    tx_end_a: assert property (tx_last_s |=> !mac_tx_valid) else $error("tx valid after last");
    tx_pad_a: assert property (tx_last_s |-> tx_cnt_ff >= 12'h03b) else $error("tx frame short");
    tx_start_a: assert property ($rose(mac_tx_valid) |-> tx_cnt_ff == 12'h000) else $error("tx count");
    rx_drain_a: assert property ($fell(mac_rx_ready) |-> ##[1:8] mac_rx_ready)
        else $error("rx stalled too long");
endmodule
bind rsp_socket0 rsp_socket0_assertions chk (.core_clk, .rst, .hsel, .htrans, .hwrite, .hreadyout, .hresp,
    .hrdata, .mac_rx_ready, .mac_tx_valid, .mac_tx_byte, .mac_tx_ready);

// ---- bench/rsp_mac_model.sv ----
// Purpose: Ethernet MAC side model
// Assumes: Tx ready toggles
// Notes: Rx frames on call
`timescale 1ns/10ps
module rsp_mac_model (
    input wire logic core_clk,
    input wire logic rst,
    output logic mac_rx_valid,
    output rsp_pkg::rsp_rx_byte_s mac_rx_byte,
    input wire logic mac_rx_ready,
    input wire logic mac_tx_valid,
    input wire rsp_pkg::rsp_tx_byte_s mac_tx_byte,
    output logic mac_tx_ready
);
    logic [7:0] txq [0:127];
    int tx_n = 0;
    int last_at = -1;
    initial begin
        mac_rx_valid = 1'b0;
        mac_rx_byte = '0;
        mac_tx_ready = 1'b0;
    end
    always @(posedge core_clk) begin
        mac_tx_ready <= ~mac_tx_ready;
        if (mac_tx_valid && mac_tx_ready && tx_n < 128) begin
            txq[tx_n] <= mac_tx_byte.data;
            tx_n <= tx_n + 1;
            if (mac_tx_byte.last) begin
                last_at <= tx_n;
            end
        end
    end
    // Addresses then counting bytes
    task automatic rx_frame(input int n, input logic bc);
        for (int i = 0; i < n; i++) begin
            mac_rx_valid <= 1'b1;
            mac_rx_byte <= '{last: (i == n - 1), data: (i < 6) ? (bc ? 8'hff : 8'h11) : 8'(i), crc: 32'h1234_5678};
            do @(posedge core_clk); while (!mac_rx_ready);
        end
        mac_rx_valid <= 1'b0;
        mac_rx_byte <= ~mac_rx_byte;
        @(posedge core_clk);
    endtask
endmodule

// ---- bench/raw_ethernet_socket_path_tb.sv ----
// Purpose: Register tests
// Assumes: MAC model on the far side
// Notes: Tx, filter, rx
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module raw_ethernet_socket_path_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = rsp_pkg::HSIZE_WORD;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, mac_rx_valid, mac_rx_ready, mac_tx_valid, mac_tx_ready;
    logic [31:0] hrdata;
    logic [31:0] rd;
    rsp_pkg::rsp_rx_byte_s mac_rx_byte;
    rsp_pkg::rsp_tx_byte_s mac_tx_byte;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    rsp_socket0 dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .mac_rx_valid, .mac_rx_byte, .mac_rx_ready, .mac_tx_valid, .mac_tx_byte, .mac_tx_ready);
    rsp_mac_model mac (.core_clk, .rst, .mac_rx_valid, .mac_rx_byte, .mac_rx_ready, .mac_tx_valid, .mac_tx_byte,
        .mac_tx_ready);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [7:0] rxb(input int i);
        return (i < 6) ? 8'hff : 8'(i);
    endfunction
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge core_clk); while (!hreadyout);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        ahb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rdchk(8'h08, 32'h0, "state");
        rdchk(8'h20, 32'h2, "rx kb");
        rdchk(8'h18, 32'h800, "tx free");
        rdchk(8'h30, 32'h0, "unmapped");
        ahb(1'b1, 8'h00, 32'h04);
        ahb(1'b1, 8'h04, 32'h01);
        rdchk(8'h08, 32'h42, "open");
        $display("test open done");
        ahb(1'b1, 8'h14, 32'haabb);
        ahb(1'b1, 8'h14, 32'hcc00);
        ahb(1'b1, 8'h1c, 32'h3);
        ahb(1'b1, 8'h04, 32'h20);
        for (int i = 0; i < 400 && mac.last_at < 0; i++) @(posedge core_clk);
        `CHK("tx last", 59, mac.last_at)
        for (int i = 0; i < 60; i++) `CHK("tx byte", (i < 3) ? 8'(8'haa + 8'(17 * i)) : 8'h00, mac.txq[i])
        repeat (4) @(posedge core_clk);
        rdchk(8'h24, 32'h10, "event");
        ahb(1'b1, 8'h24, 32'h10);
        rdchk(8'h24, 32'h0, "event clr");
        $display("test tx done");
        ahb(1'b1, 8'h04, 32'h10);
        rdchk(8'h08, 32'h0, "closed");
        ahb(1'b1, 8'h00, 32'h44);
        ahb(1'b1, 8'h04, 32'h01);
        mac.rx_frame(15, 1'b0);
        mac.rx_frame(15, 1'b1);
        repeat (8) @(posedge core_clk);
        rdchk(8'h0c, 32'h16, "rx size");
        rdchk(8'h10, 32'hf, "header");
        for (int k = 0; k < 8; k++) rdchk(8'h10, {16'h0, rxb(2 * k), (k == 7) ? 8'h00 : rxb(2 * k + 1)}, "word");
        rdchk(8'h10, 32'h1234, "crc hi");
        rdchk(8'h10, 32'h5678, "crc lo");
        ahb(1'b1, 8'h04, 32'h40);
        rdchk(8'h0c, 32'h0, "rx size done");
        $display("test rx done");
        give_verdict();
    end
endmodule
